// ==== shared/esc_pkg.sv ====
// Package: register map, field layout and reset values of the config bank
package esc_pkg;
	// ************************************************************
	// Register indices as seen on the host access port
	// ************************************************************
	localparam logic [6:0] ESC_ADDR_IN_FMT  = 7'h08;
	localparam logic [6:0] ESC_ADDR_OUT_FMT = 7'h09;
	localparam logic [6:0] ESC_ADDR_STEP    = 7'h0A;
	localparam logic [6:0] ESC_ADDR_STATSEL = 7'h0B;
	localparam logic [6:0] ESC_ADDR_CLREX   = 7'h0C;
	localparam logic [6:0] ESC_ADDR_INTR    = 7'h0D;
	localparam logic [6:0] ESC_ADDR_EVENTS  = 7'h0E;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] ESC_RST_IN_FMT  = 32'h0000_0000;
	localparam logic [31:0] ESC_RST_OUT_FMT = 32'h0000_0000;
	localparam logic [31:0] ESC_RST_STEP    = 32'h00FB_0C80;
	localparam logic [31:0] ESC_RST_STATSEL = 32'h8202_9805;
	localparam logic [31:0] ESC_RST_CLREX   = 32'h0000_0000;
	localparam logic [31:0] ESC_RST_INTR    = 32'h0000_0000;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int ESC_ANGLE_LSB  = 0;
	localparam int ESC_TURN_LSB   = 5;
	localparam int ESC_STAT_LSB   = 10;
	localparam int ESC_CRC_LSB    = 12;
	localparam int ESC_SADDR_LSB  = 16;
	localparam int ESC_SDATA_LSB  = 24;
	localparam int ESC_MSTEP_LSB  = 0;
	localparam int ESC_FSREV_LSB  = 4;
	localparam int ESC_DRVSEL_LSB = 16;
	localparam int ESC_EVT_DRIVER = 30;

	// ************************************************************
	// Codes
	// ************************************************************
	localparam logic [1:0] ESC_SER_INCR  = 2'h0;
	localparam logic [1:0] ESC_SER_SPI   = 2'h3;
	localparam logic [3:0] ESC_MSTEP_FS  = 4'h8;
	localparam logic [8:0] ESC_MSTEP_MAX = 9'h100;
	localparam int         ESC_VAR_SHIFT = 3;
endpackage : esc_pkg

// ==== core/esc_event_router.sv ====
// Module: event flags with clear-on-read, host status bits and interrupt
`timescale 1ns/1ps
module esc_event_router
	import esc_pkg::*;
#(
	parameter int EVT_W  = 32,
	parameter int STAT_W = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic [EVT_W-1:0]  eventSet,
	input  wire logic              eventsRead,
	input  wire logic [EVT_W-1:0]  clearExempt,
	input  wire logic [EVT_W-1:0]  statusSelect,
	input  wire logic [EVT_W-1:0]  intrMask,
	output logic      [EVT_W-1:0]  eventFlags_ff,
	output logic      [STAT_W-1:0] hostStatus_ff,
	output logic                   interrupt_ff
);
	generate
		if (STAT_W < 1 || STAT_W > EVT_W) begin : g_badw
			$error("esc_event_router: STAT_W out of range");
		end
	endgenerate

	logic [STAT_W-1:0] nxt_hostStatus;
	logic              irqCause;

	// Set wins over the read clear so no event is lost
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			eventFlags_ff <= '0;
		end else if (eventsRead) begin
			eventFlags_ff <= (eventFlags_ff & clearExempt) | eventSet;
		end else begin
			eventFlags_ff <= eventFlags_ff | eventSet;
		end
	end

	// Pack the lowest STAT_W selected events; later picks are dropped
	always_comb begin
		int idx;
		idx = 0;
		nxt_hostStatus = '0;
		for (int i = 0; i < EVT_W; i++) begin
			if (statusSelect[i] && idx < STAT_W) begin
				nxt_hostStatus[idx] = eventFlags_ff[i];
				idx = idx + 1;
			end
		end
	end

	assign irqCause = |(eventFlags_ff & intrMask);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hostStatus_ff <= '0;
			interrupt_ff  <= 1'b0;
		end else begin
			hostStatus_ff <= nxt_hostStatus;
			interrupt_ff  <= irqCause;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	read_clear_a: assert property (
		eventsRead && eventSet == '0 |=>
		eventFlags_ff == ($past(eventFlags_ff) & $past(clearExempt)))
		else $error("read did not clear unexempt events");
	set_wins_a: assert property (
		eventSet != '0 |=>
		(eventFlags_ff & $past(eventSet)) == $past(eventSet))
		else $error("event lost");
	irq_mask_a: assert property (
		irqCause |=> interrupt_ff)
		else $error("interrupt not raised");
	irq_quiet_a: assert property (
		!irqCause |=> !interrupt_ff)
		else $error("spurious interrupt");
endmodule : esc_event_router

// ==== core/esc_config_regs.sv ====
// Module: encoder, step and event configuration register bank
// Function
// - Position-clear bit loads encoder position on deviation
// - Velocity-limit bit enables closed-loop max-velocity regulation
// - Direction-invert bit negates encoder position
// - Output-gray bit gray-codes serial output data
// - Quadrature preprocessing only when enabled and incremental
// - Serial value valid within one eighth resolution
// - Angle field width is field plus one
// - Turn count width is field plus one
// - Frame status bit count from two-bit field
// - Checksum length from four-bit field
// - SPI encoder address and data widths
// - Output angle and turn widths plus one
// - Microstep code zero 256, eight full steps
// - Fullsteps per revolution from twelve-bit field
// - Selected driver flags raise event thirty
// - Selected events forwarded to eight status bits
// - Events read clears all but exempt flags
// - Interrupt on any masked event flag
// - Mode three selects SPI encoder options
`timescale 1ns/1ps
module esc_config_regs
	import esc_pkg::*;
#(
	parameter int STAT_W = 8
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Host register access, decoded from the host serial frames
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [6:0]  regAddr,
	input  wire logic [31:0] regWrData,
	output logic      [31:0] regRdData_ff,
	// Upper encoder configuration bits
	input  wire logic        closedLoopPositionClear,
	input  wire logic        closedLoopVelocityLimitOn,
	input  wire logic        encDirInvert,
	input  wire logic        encOutGray,
	input  wire logic        noVelPreproc,
	input  wire logic        serialVariationLimit,
	input  wire logic [1:0]  serialInMode,
	input  wire logic        closedLoopActive,
	// Datapath inputs
	input  wire logic [31:0] rampPosition,
	input  wire logic [31:0] encPosRaw,
	input  wire logic [31:0] encoderDeviation,
	input  wire logic [31:0] encoderDeviationTolerance,
	input  wire logic [31:0] serialOutValue,
	input  wire logic [31:0] serialInValue,
	input  wire logic        serialInStrobe,
	input  wire logic [31:0] encoderInputResolution,
	input  wire logic [7:0]  driverFlags,
	input  wire logic [31:0] eventSources,
	// Datapath controls
	output logic      [31:0] actualPosition_ff,
	output logic             velocityLimitActive_ff,
	output logic      [31:0] encoderPosition_ff,
	output logic      [31:0] serialOutData_ff,
	output logic             velPreprocOn_ff,
	output logic             serialAccepted_ff,
	output logic             serialRejected_ff,
	output logic      [5:0]  angleBits_ff,
	output logic      [5:0]  turnCountBits_ff,
	output logic      [1:0]  frameStatusBitCount_ff,
	output logic      [3:0]  checksumLength_ff,
	output logic      [7:0]  spiAddrBits_ff,
	output logic      [7:0]  spiDataBits_ff,
	output logic      [5:0]  outAngleBits_ff,
	output logic      [5:0]  outTurnBits_ff,
	output logic             spiEncoderMode_ff,
	output logic      [8:0]  microstepsPerFullstep_ff,
	output logic      [11:0] fullstepsPerTurn_ff,
	output logic      [31:0] eventFlags,
	output logic      [STAT_W-1:0] hostStatus,
	output logic             interruptOut
);
	generate
		if (STAT_W != 8) begin : g_badstat
			$error("esc_config_regs: host status is eight bits");
		end
	endgenerate

	// ************************************************************
	// Register file
	// ************************************************************
	logic [31:0] inFormat_ff;
	logic [31:0] outFormat_ff;
	logic [31:0] stepConfig_ff;
	logic [31:0] statusSelect_ff;
	logic [31:0] clearExempt_ff;
	logic [31:0] intrMask_ff;

	// Reserved bits are stored as written; software keeps them zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			inFormat_ff     <= ESC_RST_IN_FMT;
			outFormat_ff    <= ESC_RST_OUT_FMT;
			stepConfig_ff   <= ESC_RST_STEP;
			statusSelect_ff <= ESC_RST_STATSEL;
			clearExempt_ff  <= ESC_RST_CLREX;
			intrMask_ff     <= ESC_RST_INTR;
		end else if (regWrite) begin
			case (regAddr)
				ESC_ADDR_IN_FMT:  inFormat_ff     <= regWrData;
				ESC_ADDR_OUT_FMT: outFormat_ff    <= regWrData;
				ESC_ADDR_STEP:    stepConfig_ff   <= regWrData;
				ESC_ADDR_STATSEL: statusSelect_ff <= regWrData;
				ESC_ADDR_CLREX:   clearExempt_ff  <= regWrData;
				ESC_ADDR_INTR:    intrMask_ff     <= regWrData;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Read-back
	// ************************************************************
	logic [31:0] nxt_rdData;
	logic        eventsRead;

	assign eventsRead = regRead && regAddr == ESC_ADDR_EVENTS;

	always_comb begin
		case (regAddr)
			ESC_ADDR_IN_FMT:  nxt_rdData = inFormat_ff;
			ESC_ADDR_OUT_FMT: nxt_rdData = outFormat_ff;
			ESC_ADDR_STEP:    nxt_rdData = stepConfig_ff;
			ESC_ADDR_STATSEL: nxt_rdData = statusSelect_ff;
			ESC_ADDR_CLREX:   nxt_rdData = clearExempt_ff;
			ESC_ADDR_INTR:    nxt_rdData = intrMask_ff;
			ESC_ADDR_EVENTS:  nxt_rdData = eventFlags;
			default:          nxt_rdData = 32'h0000_0000;
		endcase
	end

	// Read data holds until the next read
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regRdData_ff <= 32'h0000_0000;
		end else if (regRead) begin
			regRdData_ff <= nxt_rdData;
		end
	end

	// ************************************************************
	// Closed loop position and velocity limit
	// ************************************************************
	logic deviationExceeded;

	assign deviationExceeded = encoderDeviation > encoderDeviationTolerance;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			actualPosition_ff <= 32'h0000_0000;
		end else if (closedLoopPositionClear && deviationExceeded) begin
			actualPosition_ff <= encoderPosition_ff;
		end else begin
			actualPosition_ff <= rampPosition;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			velocityLimitActive_ff <= 1'b0;
		end else begin
			velocityLimitActive_ff <=
				closedLoopVelocityLimitOn && closedLoopActive;
		end
	end

	// ************************************************************
	// Encoder position, output coding, preprocessing
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			encoderPosition_ff <= 32'h0000_0000;
		end else if (encDirInvert) begin
			encoderPosition_ff <= 32'h0000_0000 - encPosRaw;
		end else begin
			encoderPosition_ff <= encPosRaw;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			serialOutData_ff <= 32'h0000_0000;
		end else if (encOutGray) begin
			serialOutData_ff <= serialOutValue ^ (serialOutValue >> 1);
		end else begin
			serialOutData_ff <= serialOutValue;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			velPreprocOn_ff <= 1'b0;
		end else begin
			velPreprocOn_ff <= !noVelPreproc &&
				serialInMode == ESC_SER_INCR;
		end
	end

	// ************************************************************
	// Serial input variation check
	// ************************************************************
	logic [31:0] prevSerial_ff;
	logic [31:0] serialDelta;
	logic [31:0] serialAbsDelta;
	logic [31:0] variationBound;
	logic        variationOn;
	logic        variationOk;

	assign serialDelta    = serialInValue - prevSerial_ff;
	assign serialAbsDelta = serialDelta[31] ? 32'h0000_0000 - serialDelta
	                                        : serialDelta;
	assign variationBound = encoderInputResolution >> ESC_VAR_SHIFT;
	assign variationOn    = serialVariationLimit &&
	                        serialInMode != ESC_SER_INCR;
	assign variationOk    = !variationOn ||
	                        serialAbsDelta <= variationBound;

	// Every received value becomes the reference, valid or not
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prevSerial_ff     <= 32'h0000_0000;
			serialAccepted_ff <= 1'b0;
			serialRejected_ff <= 1'b0;
		end else begin
			serialAccepted_ff <= serialInStrobe && variationOk;
			serialRejected_ff <= serialInStrobe && !variationOk;
			if (serialInStrobe) begin
				prevSerial_ff <= serialInValue;
			end
		end
	end

	// ************************************************************
	// Frame format decode
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			angleBits_ff           <= 6'h01;
			turnCountBits_ff       <= 6'h01;
			frameStatusBitCount_ff <= 2'h0;
			checksumLength_ff      <= 4'h0;
			spiAddrBits_ff         <= 8'h00;
			spiDataBits_ff         <= 8'h00;
			outAngleBits_ff        <= 6'h01;
			outTurnBits_ff         <= 6'h01;
			spiEncoderMode_ff      <= 1'b0;
		end else begin
			angleBits_ff <= {1'b0,
				inFormat_ff[ESC_ANGLE_LSB +: 5]} + 6'h01;
			turnCountBits_ff <= {1'b0,
				inFormat_ff[ESC_TURN_LSB +: 5]} + 6'h01;
			frameStatusBitCount_ff <=
				inFormat_ff[ESC_STAT_LSB +: 2];
			checksumLength_ff <= inFormat_ff[ESC_CRC_LSB +: 4];
			spiAddrBits_ff <= inFormat_ff[ESC_SADDR_LSB +: 8];
			spiDataBits_ff <= inFormat_ff[ESC_SDATA_LSB +: 8];
			outAngleBits_ff <= {1'b0,
				outFormat_ff[ESC_ANGLE_LSB +: 5]} + 6'h01;
			outTurnBits_ff <= {1'b0,
				outFormat_ff[ESC_TURN_LSB +: 5]} + 6'h01;
			spiEncoderMode_ff <= serialInMode == ESC_SER_SPI;
		end
	end

	// ************************************************************
	// Step resolution
	// ************************************************************
	logic [3:0] mstepCode;

	assign mstepCode = stepConfig_ff[ESC_MSTEP_LSB +: 4];

	// Codes above full step are not allowed; they clamp to full step
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			microstepsPerFullstep_ff <= ESC_MSTEP_MAX;
			fullstepsPerTurn_ff      <= ESC_RST_STEP[ESC_FSREV_LSB +: 12];
		end else begin
			microstepsPerFullstep_ff <= (mstepCode > ESC_MSTEP_FS)
				? 9'h001 : ESC_MSTEP_MAX >> mstepCode;
			fullstepsPerTurn_ff <=
				stepConfig_ff[ESC_FSREV_LSB +: 12];
		end
	end

	// ************************************************************
	// Events
	// ************************************************************
	logic [31:0] eventSet;
	logic        driverEvent;

	assign driverEvent = |(driverFlags &
		stepConfig_ff[ESC_DRVSEL_LSB +: 8]);

	always_comb begin
		eventSet = eventSources;
		eventSet[ESC_EVT_DRIVER] = eventSources[ESC_EVT_DRIVER] |
		                           driverEvent;
	end

	esc_event_router #(
		.EVT_W  (32),
		.STAT_W (STAT_W)
	) u_router (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.eventSet      (eventSet),
		.eventsRead    (eventsRead),
		.clearExempt   (clearExempt_ff),
		.statusSelect  (statusSelect_ff),
		.intrMask      (intrMask_ff),
		.eventFlags_ff (eventFlags),
		.hostStatus_ff (hostStatus),
		.interrupt_ff  (interruptOut)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence stepWrite;
		regWrite && regAddr == ESC_ADDR_STEP;
	endsequence
	sequence stepReadBack;
		regRead && !regWrite && regAddr == ESC_ADDR_STEP;
	endsequence

	// Host accesses leave one idle cycle between a write and the read-back
	step_readback_a: assert property (
		stepWrite ##1 !regWrite ##1 stepReadBack |=>
		regRdData_ff == $past(regWrData, 3))
		else $error("step config read-back mismatch");
	pos_clear_a: assert property (
		closedLoopPositionClear && deviationExceeded |=>
		actualPosition_ff == $past(encoderPosition_ff))
		else $error("position not loaded from encoder");
	pos_keep_a: assert property (
		!closedLoopPositionClear |=>
		actualPosition_ff == $past(rampPosition))
		else $error("deviation altered position");
	gray_out_a: assert property (
		encOutGray |=> serialOutData_ff ==
		($past(serialOutValue) ^ ($past(serialOutValue) >> 1)))
		else $error("output not gray coded");
	preproc_gate_a: assert property (
		serialInMode != ESC_SER_INCR |=> !velPreprocOn_ff)
		else $error("preprocessing outside incremental mode");
	variation_reject_a: assert property (
		serialInStrobe && variationOn &&
		serialAbsDelta > variationBound |=>
		serialRejected_ff && !serialAccepted_ff)
		else $error("out of range serial value accepted");
	mstep_full_a: assert property (
		mstepCode == ESC_MSTEP_FS |=> microstepsPerFullstep_ff == 9'h001)
		else $error("full step code wrong");
	driver_event_a: assert property (
		driverEvent |=> eventFlags[ESC_EVT_DRIVER])
		else $error("driver event not raised");
	spi_mode_a: assert property (
		serialInMode == ESC_SER_SPI |=> spiEncoderMode_ff)
		else $error("SPI encoder mode not flagged");
endmodule : esc_config_regs

// ==== tb/tb_top.sv ====
// Testbench: self-checking bench for the encoder, step and event config bank
`timescale 1ns/1ps
module tb_top;
	import esc_pkg::*;

	// ************************************************************
	// Signals
	// ************************************************************
	logic        ref_clk, sys_rst, regWrite, regRead, serialInStrobe;
	logic [6:0]  regAddr;
	logic [31:0] regWrData, regRdData_ff;
	logic        closedLoopPositionClear, closedLoopVelocityLimitOn;
	logic        encDirInvert, encOutGray, noVelPreproc;
	logic        serialVariationLimit, closedLoopActive;
	logic [1:0]  serialInMode, frameStatusBitCount_ff;
	logic [31:0] rampPosition, encPosRaw, encoderDeviation;
	logic [31:0] encoderDeviationTolerance, serialOutValue, serialInValue;
	logic [31:0] encoderInputResolution, eventSources;
	logic [7:0]  driverFlags, spiAddrBits_ff, spiDataBits_ff, hostStatus;
	logic [31:0] actualPosition_ff, encoderPosition_ff, serialOutData_ff;
	logic [31:0] eventFlags;
	logic        velocityLimitActive_ff, velPreprocOn_ff, spiEncoderMode_ff;
	logic        serialAccepted_ff, serialRejected_ff, interruptOut;
	logic [5:0]  angleBits_ff, turnCountBits_ff, outAngleBits_ff;
	logic [5:0]  outTurnBits_ff;
	logic [3:0]  checksumLength_ff;
	logic [8:0]  microstepsPerFullstep_ff;
	logic [11:0] fullstepsPerTurn_ff;
	int          failures, numChecks;
	integer      seed;
	logic [31:0] rd, r, a, b, e, prev, bound, flagModel;
	logic        acc, rej;
	logic [31:0] regs [6];
	logic [31:0] rstVal [6] = '{ESC_RST_IN_FMT, ESC_RST_OUT_FMT,
		ESC_RST_STEP, ESC_RST_STATSEL, ESC_RST_CLREX, ESC_RST_INTR};

	esc_config_regs #(.STAT_W(8)) u_dut (.ref_clk, .sys_rst, .regWrite,
		.regRead, .regAddr, .regWrData, .regRdData_ff,
		.closedLoopPositionClear, .closedLoopVelocityLimitOn, .encDirInvert,
		.encOutGray, .noVelPreproc, .serialVariationLimit, .serialInMode,
		.closedLoopActive, .rampPosition, .encPosRaw, .encoderDeviation,
		.encoderDeviationTolerance, .serialOutValue, .serialInValue,
		.serialInStrobe, .encoderInputResolution, .driverFlags,
		.eventSources, .actualPosition_ff, .velocityLimitActive_ff,
		.encoderPosition_ff, .serialOutData_ff, .velPreprocOn_ff,
		.serialAccepted_ff, .serialRejected_ff, .angleBits_ff,
		.turnCountBits_ff, .frameStatusBitCount_ff, .checksumLength_ff,
		.spiAddrBits_ff, .spiDataBits_ff, .outAngleBits_ff, .outTurnBits_ff,
		.spiEncoderMode_ff, .microstepsPerFullstep_ff, .fullstepsPerTurn_ff,
		.eventFlags, .hostStatus, .interruptOut);

	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cyc

	task automatic reg_write(input logic [6:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr   <= ad;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge ref_clk);
		regWrite  <= 1'b0;
	endtask : reg_write

	// Data is sampled one edge late; it holds until the next read anyway
	task automatic reg_read(input logic [6:0] ad, output logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= ad;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		wait_cyc(1);
		d = regRdData_ff;
	endtask : reg_read

	function automatic logic [8:0] exp_mstep(input logic [3:0] c);
		return (c <= 4'h8) ? (9'h100 >> c) : 9'h001;
	endfunction : exp_mstep

	function automatic logic [7:0] exp_status(input logic [31:0] f, sel);
		int k;
		logic [7:0] s;
		k = 0;
		s = 8'h00;
		for (int i = 0; i < 32; i++) begin
			if (sel[i]) begin
				if (k < 8) s[k] = f[i];
				k++;
			end
		end
		return s;
	endfunction : exp_status

	task automatic end_test(input string name);
		$display("Test %s finished", name);
	endtask : end_test

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		tally_and_finish();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		seed = 32'hBB27;
		{regWrite, regRead, serialInStrobe, closedLoopActive} <= 4'h0;
		{closedLoopPositionClear, closedLoopVelocityLimitOn} <= 2'h0;
		{encDirInvert, encOutGray, noVelPreproc} <= 3'h0;
		serialVariationLimit <= 1'b0;
		serialInMode <= 2'h0;
		regAddr <= 7'h00;
		{regWrData, rampPosition, encPosRaw, encoderDeviation} <= 128'h0;
		{encoderDeviationTolerance, serialOutValue, serialInValue} <= 96'h0;
		{encoderInputResolution, eventSources} <= 64'h0;
		driverFlags <= 8'h00;
		sys_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;

		for (int i = 0; i < 6; i++) begin
			reg_read(ESC_ADDR_IN_FMT + 7'(i), rd);
			check("reset value", rd, rstVal[i]);
		end
		check("reset microsteps", microstepsPerFullstep_ff, 32'h100);
		check("reset fullsteps", fullstepsPerTurn_ff, 32'hC8);
		check("reset angle bits", angleBits_ff, 32'h1);
		end_test("reset");

		for (int i = 0; i < 6; i++) begin
			regs[i] = $random(seed);
			// Upper output format bits must be written as zero
			if (i == 1) regs[i] = regs[i] & 32'h0000_03FF;
			reg_write(ESC_ADDR_IN_FMT + 7'(i), regs[i]);
			reg_read(ESC_ADDR_IN_FMT + 7'(i), rd);
			check("readback", rd, regs[i]);
		end
		r = regs[0];
		check("angle bits", angleBits_ff, 32'(r[4:0]) + 32'h1);
		check("turn bits", turnCountBits_ff, 32'(r[9:5]) + 32'h1);
		check("status count", frameStatusBitCount_ff, r[11:10]);
		check("checksum length", checksumLength_ff, r[15:12]);
		check("spi addr bits", spiAddrBits_ff, r[23:16]);
		check("spi data bits", spiDataBits_ff, r[31:24]);
		r = regs[1];
		check("out angle", outAngleBits_ff, 32'(r[4:0]) + 32'h1);
		check("out turn", outTurnBits_ff, 32'(r[9:5]) + 32'h1);
		check("fullsteps", fullstepsPerTurn_ff, regs[2][15:4]);
		reg_write(7'h10, 32'hFFFF_FFFF);
		reg_read(7'h10, rd);
		check("unmapped read", rd, 32'h0);
		reg_write(ESC_ADDR_EVENTS, 32'hFFFF_FFFF);
		reg_read(ESC_ADDR_EVENTS, rd);
		check("events not writable", rd, 32'h0);
		for (int c = 0; c < 16; c++) begin
			reg_write(ESC_ADDR_STEP, {regs[2][31:4], 4'(c)});
			wait_cyc(2);
			check("microsteps", microstepsPerFullstep_ff, exp_mstep(4'(c)));
		end
		// Closed-loop scenarios below run at the finest resolution
		reg_write(ESC_ADDR_STEP, {regs[2][31:4], 4'h0});
		wait_cyc(2);
		check("finest microsteps", microstepsPerFullstep_ff, 32'h100);
		end_test("registers");

		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			a = $random(seed);
			b = (i % 4 == 0) ? a : $random(seed);
			@(posedge ref_clk);
			closedLoopPositionClear   <= r[0];
			closedLoopVelocityLimitOn <= r[1];
			encDirInvert              <= r[2];
			encOutGray                <= r[3];
			noVelPreproc              <= r[4];
			closedLoopActive          <= r[5];
			serialInMode              <= r[7:6];
			encoderDeviation          <= a;
			encoderDeviationTolerance <= b;
			encPosRaw                 <= $random(seed);
			rampPosition              <= $random(seed);
			serialOutValue            <= $random(seed);
			wait_cyc(4);
			e = r[2] ? -encPosRaw : encPosRaw;
			check("encoder position", encoderPosition_ff, e);
			e = (r[0] && a > b) ? e : rampPosition;
			check("actual position", actualPosition_ff, e);
			check("velocity limit", velocityLimitActive_ff, r[1] & r[5]);
			e = r[3] ? (serialOutValue ^ (serialOutValue >> 1)) : serialOutValue;
			check("serial out", serialOutData_ff, e);
			check("preprocess", velPreprocOn_ff, !r[4] && r[7:6] == 2'h0);
			check("spi mode", spiEncoderMode_ff, r[7:6] == ESC_SER_SPI);
		end
		end_test("datapath");

		@(posedge ref_clk);
		serialVariationLimit   <= 1'b1;
		serialInMode           <= 2'h1;
		encoderInputResolution <= ($random(seed) & 32'h000F_FFF0) | 32'h80;
		wait_cyc(1);
		bound = encoderInputResolution >> 3;
		prev = 32'h0;
		for (int i = 0; i < 25; i++) begin
			r = $random(seed);
			case (i % 5)
				0: a = bound;
				1: a = bound + 32'h1;
				2: a = -bound;
				3: a = -(bound + 32'h1);
				default: a = r & 32'h0001_FFFF;
			endcase
			@(posedge ref_clk);
			serialInStrobe <= 1'b1;
			serialInValue  <= prev + a;
			@(posedge ref_clk);
			serialInStrobe <= 1'b0;
			#1;
			acc = serialAccepted_ff;
			rej = serialRejected_ff;
			wait_cyc(1);
			acc = acc | serialAccepted_ff;
			rej = rej | serialRejected_ff;
			if (a[31]) a = -a;
			check("serial accept", acc, a <= bound);
			check("serial reject", rej, a > bound);
			prev = serialInValue;
		end
		end_test("serial check");

		reg_read(ESC_ADDR_EVENTS, rd);
		flagModel = 32'h0;
		for (int i = 0; i < 16; i++) begin
			if (i == 8) begin
				regs[5] = 32'h0;
				reg_write(ESC_ADDR_INTR, regs[5]);
			end
			a = $random(seed) & $random(seed);
			b = $random(seed);
			@(posedge ref_clk);
			eventSources <= a;
			driverFlags  <= b[7:0];
			@(posedge ref_clk);
			eventSources <= 32'h0;
			driverFlags  <= 8'h00;
			wait_cyc(3);
			flagModel = flagModel | a;
			if ((b[7:0] & regs[2][23:16]) != 8'h00) flagModel[30] = 1'b1;
			check("event flags", eventFlags, flagModel);
			check("host status", hostStatus, exp_status(flagModel, regs[3]));
			check("interrupt", interruptOut, |(flagModel & regs[5]));
			if (i % 2 == 1) begin
				reg_read(ESC_ADDR_EVENTS, rd);
				check("events read", rd, flagModel);
				// Masking after the read, since the read returns pre-clear flags
				flagModel = flagModel & regs[4];
				wait_cyc(1);
				check("flags after read", eventFlags, flagModel);
			end
		end
		// Corner: an event raised in the clearing cycle must survive the read
		a = $random(seed);
		@(posedge ref_clk);
		regAddr      <= ESC_ADDR_EVENTS;
		regRead      <= 1'b1;
		eventSources <= a;
		@(posedge ref_clk);
		regRead      <= 1'b0;
		eventSources <= 32'h0;
		wait_cyc(2);
		flagModel = (flagModel & regs[4]) | a;
		check("set beats clear", eventFlags, flagModel);
		end_test("events");
		tally_and_finish();
	end
endmodule : tb_top
